// file: src/rca_pkg.sv
// Package with constants and types for the remote command and alarm logic.
// Contract
// - Up to 64 command outputs, each usable only after mapping to a channel.
// - Momentary: mapped output is active only while raise or lower is held.
// - Each channel has raise and lower entries; writing zero clears an entry.
// - Reading a mapping shows the output number, or zero when unmapped.
// - Same output on raise and lower latches: raise sets, lower clears.
// - Completing a latching map shows off; raise turns on and lights raise.
// - Clearing both entries of a latching channel forces its output off.
// - One momentary output may be mapped to several channels at once.
// - An assigned mute status that is off stops limit checking.
// - Checking resumes four seconds after the mute status returns on.
// - Zero removes a mute assignment; reading shows it or zero.
// - Several telemetry channels may share one mute status, gated independently.
// - Alarms: status edges, low and high limit violations, failsafe start and expiry.
// - A new alarm sounds if enabled and flashes the display until acknowledged.
// - First acknowledge silences and selects the earliest pending alarm channel.
// - After first acknowledge the cause indicator flashes at 2 Hz.
// - Second acknowledge clears the selected alarm and stops its flashing.
// - A remaining limit violation stays steadily lit until gone, disabled or muted.
// - Lamp test key toggles lighting of all indicators and digits.
// - Override key toggles override mode; its indicator shows the mode.
// - In override, distant raise/lower is ignored and failsafe is ended.
// - Out of override, local raise and lower keys drive no output.
// - Edges and muting use status after latch and invert processing.
// - While failsafe is active out of override every command output is held inactive.
package rca_pkg;
  // Timing.
  localparam int CLK_HZ = 100_000_000;
  localparam int MUTE_HOLD_S = 4;
  localparam int MUTE_HOLD_CYC = MUTE_HOLD_S * CLK_HZ;
  localparam int FLASH_HZ = 2;
  localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  // Sizes and limits.
  localparam int NUM_CH = 32;
  localparam int NUM_SRC = 6;
  localparam int Q_DEPTH = 8;
  localparam logic [6:0] CMD_MAX = 7'h40;
  localparam logic [5:0] MUTE_MAX = 6'h20;
  // Register byte offsets.
  localparam logic [7:0] OFS_CHAN = 8'h00;
  localparam logic [7:0] OFS_KEYS = 8'h04;
  localparam logic [7:0] OFS_MAP = 8'h08;
  localparam logic [7:0] OFS_MUTE = 8'h0c;
  localparam logic [7:0] OFS_RISE = 8'h10;
  localparam logic [7:0] OFS_FALL = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_NONE = 8'hff;
  // Field positions.
  localparam int KEY_RAISE = 0;
  localparam int KEY_LOWER = 1;
  localparam int KEY_ACK = 2;
  localparam int KEY_LAMP = 3;
  localparam int KEY_OVR = 4;
  localparam int MAP_LOWER_SEL = 8;
  // Reset values.
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [31:0] EDGE_EN_RST = 32'h0000_0000;
  // Alarm causes; the code is also the source group in the pending vector.
  typedef enum logic [2:0] {
    CAUSE_FALL = 3'b000,
    CAUSE_RISE = 3'b001,
    CAUSE_LOW = 3'b010,
    CAUSE_HIGH = 3'b011,
    CAUSE_FS_START = 3'b100,
    CAUSE_FS_EXPIRE = 3'b101
  } rca_cause_t;
  typedef enum logic {
    ACK_WAIT = 1'b0,
    ACK_SHOWN = 1'b1
  } rca_ack_t;
  typedef struct packed {
    rca_cause_t cause;
    logic [4:0] chan;
  } rca_alarm_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } rca_aphase_t;
endpackage

// file: src/rca_mute_gate.sv
// Per-channel mute gate that holds off limit checking after its status returns.
`timescale 1ns/1ps
module rca_mute_gate #(
  parameter int HOLD_CYC = rca_pkg::MUTE_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Assignment and sources
  input wire logic [5:0] mute_sel,
  input wire logic [31:0] status,
  input wire logic limits_on,
  // Gate result
  output logic chk_en
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic chk_reg;
  logic chk_next;

  // Each instance reads the shared status bus on its own, so channels never interact.
  wire assigned = mute_sel != 6'h00;
  wire [4:0] src_idx = 5'(mute_sel - 6'h01);
  wire src_on = status[src_idx];
  assign cnt_next = !assigned ? '0 : !src_on ? CW'(HOLD_CYC) :
    (cnt_reg != '0) ? cnt_reg - 1'b1 : '0;
  assign chk_next = limits_on & (~assigned | (src_on & (cnt_reg == '0)));
  assign chk_en = chk_reg;

  // Hold counter and gate flop.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      chk_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      chk_reg <= chk_next;
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  a_mute_stops_check: assert property (assigned && !src_on |=> !chk_en)
    else $error("Checking not stopped by mute.");
  a_mute_hold_delay: assert property (assigned && src_on && cnt_reg != '0 |=> !chk_en)
    else $error("Checking resumed before the hold time.");
  c_mute_resume: cover property (assigned && !src_on ##1 src_on);
endmodule // rca_mute_gate

// file: src/rca_top.sv
// Front-panel command mapping, mute gating, alarm queue and override logic.
`timescale 1ns/1ps
module rca_top #(
  parameter int MUTE_HOLD_CYC = rca_pkg::MUTE_HOLD_CYC,
  parameter int FLASH_HALF_CYC = rca_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Processed status, limit comparisons, alarm enable
  input wire logic [31:0] STATUS_VAL,
  input wire logic [31:0] LOW_VIOL,
  input wire logic [31:0] HIGH_VIOL,
  input wire logic LIMITS_ON,
  input wire logic ALARM_ENABLE,
  // Failsafe
  input wire logic FS_ACTIVE,
  input wire logic FS_START,
  input wire logic FS_EXPIRE,
  // Distant control terminal commands
  input wire logic [4:0] RMT_CHAN,
  input wire logic RMT_RAISE,
  input wire logic RMT_LOWER,
  // Command relays and override
  output logic [63:0] CMD_OUT,
  output logic FS_TERMINATE,
  // Front panel
  output logic RAISE_LED,
  output logic LOWER_LED,
  output logic OVERRIDE_LED,
  output logic LAMP_TEST,
  output logic AUDIBLE,
  output logic DISP_FLASH,
  output logic [31:0] STATUS_LED,
  output logic LOW_LED,
  output logic OVER_LIMIT_LED,
  output logic [31:0] CHK_EN
);
  localparam int NPEND = rca_pkg::NUM_SRC * rca_pkg::NUM_CH;
  localparam int FW = $clog2(FLASH_HALF_CYC);

  // Output number n (1..64) as a one-hot relay vector; zero maps to nothing.
  function automatic logic [63:0] out_bit(input logic [6:0] n);
    out_bit = (n == 7'h00) ? 64'h0 : 64'h1 << (n - 7'h01);
  endfunction

  // Lowest set pending bit; its group is the cause and its offset the channel.
  function automatic logic [7:0] first_set(input logic [NPEND-1:0] v);
    first_set = 8'h00;
    for (int i = NPEND - 1; i >= 0; i--)
      if (v[i])
        first_set = 8'(i);
  endfunction

  rca_pkg::rca_aphase_t ap_reg;
  rca_pkg::rca_aphase_t ap_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_val;
  logic rdy_reg;
  logic resp_reg;
  logic [4:0] sel_reg;
  logic [4:0] sel_next;
  logic [1:0] hold_reg;
  logic lamp_reg;
  logic ovr_reg;
  logic [6:0] rmap_reg [rca_pkg::NUM_CH];
  logic [6:0] lmap_reg [rca_pkg::NUM_CH];
  logic [5:0] mute_reg [rca_pkg::NUM_CH];
  logic [31:0] rise_en_reg;
  logic [31:0] fall_en_reg;
  logic [63:0] latch_reg;
  logic [63:0] latch_next;
  logic [63:0] cmd_reg;
  logic [63:0] cmd_next;
  logic prev_r_reg;
  logic prev_l_reg;
  logic [31:0] st_prev_reg;
  logic [31:0] lo_prev_reg;
  logic [31:0] hi_prev_reg;
  logic [NPEND-1:0] pend_reg;
  logic [NPEND-1:0] pend_next;
  rca_pkg::rca_alarm_t q_reg [rca_pkg::Q_DEPTH];
  logic [2:0] wp_reg;
  logic [2:0] rp_reg;
  logic [3:0] qcnt_reg;
  logic [3:0] qcnt_next;
  rca_pkg::rca_ack_t ack_reg;
  rca_pkg::rca_ack_t ack_next;
  logic alert_reg;
  logic alert_next;
  logic [FW-1:0] fcnt_reg;
  logic flash_reg;
  logic rled_reg;
  logic lled_reg;
  logic oled_reg;
  logic aud_reg;
  logic dflash_reg;
  logic [31:0] sled_reg;
  logic [31:0] sled_next;
  logic lowled_reg;
  logic hiled_reg;
  logic [31:0] chk_en;

  // Bus decode. The slave never stalls, so a read is answered in its data phase.
  wire ap_take = HSEL & HTRANS[1] & HREADY;
  wire ap_hit = HADDR[31:8] == 24'h000000;
  wire [7:0] ra = HADDR[7:0];
  assign ap_next = '{valid: ap_take, write: HWRITE,
    addr: ap_hit ? ra : rca_pkg::OFS_NONE};
  wire wr_go = ap_reg.valid & ap_reg.write;
  wire wr_chan = wr_go & (ap_reg.addr == rca_pkg::OFS_CHAN);
  wire wr_keys = wr_go & (ap_reg.addr == rca_pkg::OFS_KEYS);
  wire wr_map = wr_go & (ap_reg.addr == rca_pkg::OFS_MAP);
  wire wr_mute = wr_go & (ap_reg.addr == rca_pkg::OFS_MUTE);
  wire wr_rise = wr_go & (ap_reg.addr == rca_pkg::OFS_RISE);
  wire wr_fall = wr_go & (ap_reg.addr == rca_pkg::OFS_FALL);

  // Key strobes are one-cycle pulses taken from the write data.
  wire ack_p = wr_keys & HWDATA[rca_pkg::KEY_ACK];
  wire lamp_p = wr_keys & HWDATA[rca_pkg::KEY_LAMP];
  wire ovr_p = wr_keys & HWDATA[rca_pkg::KEY_OVR];

  // Mapping and mute writes; out-of-range numbers are dropped whole.
  wire [6:0] wm_num = HWDATA[6:0];
  wire wm_low = HWDATA[rca_pkg::MAP_LOWER_SEL];
  wire wm_ok = wr_map & (wm_num <= rca_pkg::CMD_MAX);
  wire wu_ok = wr_mute & (HWDATA[5:0] <= rca_pkg::MUTE_MAX);

  // Selected-channel view of the mapping store.
  wire [6:0] sr = rmap_reg[sel_reg];
  wire [6:0] sl = lmap_reg[sel_reg];
  wire sel_latch = (sr == sl) & (sr != 7'h00);
  wire [6:0] nr = wm_low ? sr : wm_num;
  wire [6:0] nl = wm_low ? wm_num : sl;
  wire new_latch = (nr == nl) & (nr != 7'h00);

  // Command authority follows the override mode.
  wire [4:0] src_chan = ovr_reg ? sel_reg : RMT_CHAN;
  wire src_raise = ovr_reg ? hold_reg[rca_pkg::KEY_RAISE] : RMT_RAISE;
  wire src_lower = ovr_reg ? hold_reg[rca_pkg::KEY_LOWER] : RMT_LOWER;
  wire [6:0] cr = rmap_reg[src_chan];
  wire [6:0] cl = lmap_reg[src_chan];
  wire src_latch = (cr == cl) & (cr != 7'h00);
  wire press_r = src_raise & ~prev_r_reg;
  wire press_l = src_lower & ~prev_l_reg;

  // Momentary outputs follow the held key; any channel may share a number.
  wire [63:0] mom = ((src_raise & ~src_latch) ? out_bit(cr) : 64'h0) |
    ((src_lower & ~src_latch) ? out_bit(cl) : 64'h0);

  // A new latching pair starts off; breaking a pair drops its old output.
  wire [63:0] clr_map = (wm_ok & new_latch ? out_bit(nr) : 64'h0) |
    (wm_ok & sel_latch & ~new_latch ? out_bit(sr) : 64'h0);
  wire [63:0] set_vec = (press_r & src_latch) ? out_bit(cr) : 64'h0;
  wire [63:0] clr_key = (press_l & src_latch) ? out_bit(cr) : 64'h0;
  assign latch_next = (latch_reg & ~clr_map & ~clr_key) | set_vec;

  // Failsafe blocks every relay unless override has ended it.
  wire fs_block = FS_ACTIVE & ~ovr_reg;
  assign cmd_next = fs_block ? 64'h0 : (mom | latch_reg);

  // Edges on processed status and on gated limit violations.
  wire [31:0] st_rise = STATUS_VAL & ~st_prev_reg & rise_en_reg;
  wire [31:0] st_fall = ~STATUS_VAL & st_prev_reg & fall_en_reg;
  wire [31:0] lo_act = LOW_VIOL & chk_en;
  wire [31:0] hi_act = HIGH_VIOL & chk_en;
  wire [31:0] lo_evt = lo_act & ~lo_prev_reg;
  wire [31:0] hi_evt = hi_act & ~hi_prev_reg;
  wire [NPEND-1:0] new_evt = {31'h0, FS_EXPIRE, 31'h0, FS_START,
    hi_evt, lo_evt, st_rise, st_fall};

  // One pending event per cycle moves into the queue; a new one beats the clear.
  wire q_full = qcnt_reg == 4'(rca_pkg::Q_DEPTH);
  wire push = (|pend_reg) & ~q_full;
  wire [7:0] pick = first_set(pend_reg);
  wire [NPEND-1:0] pick_bit = push ? (NPEND'(1) << pick) : '0;
  assign pend_next = (pend_reg & ~pick_bit) | new_evt;
  wire rca_pkg::rca_alarm_t new_ent = '{cause: rca_pkg::rca_cause_t'(pick[7:5]),
    chan: pick[4:0]};
  wire rca_pkg::rca_alarm_t head = q_reg[rp_reg];

  // Acknowledge pairs: first shows the oldest alarm, second retires it.
  wire first = ack_p & (ack_reg == rca_pkg::ACK_WAIT) & (qcnt_reg != 4'h0);
  wire second = ack_p & (ack_reg == rca_pkg::ACK_SHOWN);
  assign qcnt_next = 4'(qcnt_reg + {3'h0, push} - {3'h0, second});
  assign alert_next = push | (alert_reg & ~first) |
    (second & (qcnt_reg > 4'h1));

  always_comb
  begin
    unique case (ack_reg)
      rca_pkg::ACK_WAIT: ack_next = first ? rca_pkg::ACK_SHOWN : rca_pkg::ACK_WAIT;
      rca_pkg::ACK_SHOWN: ack_next = second ? rca_pkg::ACK_WAIT : rca_pkg::ACK_SHOWN;
    endcase
  end

  // Software may select a channel; the first acknowledge moves to the alarm.
  assign sel_next = wr_chan ? HWDATA[4:0] : first ? head.chan : sel_reg;

  // Cause indicators: flashing while shown, steady for a live violation.
  wire shown = ack_reg == rca_pkg::ACK_SHOWN;
  wire hd_stat = shown & ((head.cause == rca_pkg::CAUSE_FALL) |
    (head.cause == rca_pkg::CAUSE_RISE));
  wire hd_sel = shown & (head.chan == sel_reg);
  wire [31:0] st_mask = hd_stat ? (32'h1 << head.chan) : 32'h0;
  assign sled_next = lamp_reg ? 32'hffff_ffff :
    (STATUS_VAL & ~st_mask) | (st_mask & {32{flash_reg}});
  wire low_next = lamp_reg | ((hd_sel & (head.cause == rca_pkg::CAUSE_LOW)) ?
    flash_reg : lo_act[sel_reg]);
  wire hi_next = lamp_reg | ((hd_sel & (head.cause == rca_pkg::CAUSE_HIGH)) ?
    flash_reg : hi_act[sel_reg]);
  wire on_now = |(latch_reg & out_bit(sr));
  wire fwrap = fcnt_reg == FW'(FLASH_HALF_CYC - 1);

  // Register read selection.
  assign rd_val = (ra == rca_pkg::OFS_CHAN) ? {27'h0, sel_reg} :
    (ra == rca_pkg::OFS_KEYS) ? {30'h0, hold_reg} :
    (ra == rca_pkg::OFS_MAP) ? {17'h0, sl, 1'b0, sr} :
    (ra == rca_pkg::OFS_MUTE) ? {26'h0, mute_reg[sel_reg]} :
    (ra == rca_pkg::OFS_RISE) ? rise_en_reg :
    (ra == rca_pkg::OFS_FALL) ? fall_en_reg :
    (ra == rca_pkg::OFS_STATE) ? {11'h0, head.chan, 5'h0, head.cause, qcnt_reg,
      shown, alert_reg, lamp_reg, ovr_reg} : 32'h0;
  assign rdata_next = (ap_take & ~HWRITE & ap_hit) ? rd_val : 32'h0;

  // Bus slave state; the response is always OKAY with no wait states.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ap_reg <= '0;
      rdata_reg <= 32'h0;
      rdy_reg <= 1'b1;
      resp_reg <= 1'b0;
    end
    else
    begin
      ap_reg <= ap_next;
      rdata_reg <= rdata_next;
      rdy_reg <= 1'b1;
      resp_reg <= 1'b0;
    end
  end

  // Panel modes and software-written settings.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      sel_reg <= rca_pkg::CHAN_RST;
      hold_reg <= 2'h0;
      lamp_reg <= 1'b0;
      ovr_reg <= 1'b0;
      rise_en_reg <= rca_pkg::EDGE_EN_RST;
      fall_en_reg <= rca_pkg::EDGE_EN_RST;
    end
    else
    begin
      sel_reg <= sel_next;
      hold_reg <= wr_keys ? HWDATA[1:0] : hold_reg;
      lamp_reg <= lamp_reg ^ lamp_p;
      ovr_reg <= ovr_reg ^ ovr_p;
      rise_en_reg <= wr_rise ? HWDATA : rise_en_reg;
      fall_en_reg <= wr_fall ? HWDATA : fall_en_reg;
    end
  end

  // Mapping and mute store, written for the selected channel only.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < rca_pkg::NUM_CH; i++)
      begin
        rmap_reg[i] <= 7'h00;
        lmap_reg[i] <= 7'h00;
        mute_reg[i] <= 6'h00;
      end
    end
    else
    begin
      if (wm_ok && !wm_low)
        rmap_reg[sel_reg] <= wm_num;
      if (wm_ok && wm_low)
        lmap_reg[sel_reg] <= wm_num;
      if (wu_ok)
        mute_reg[sel_reg] <= HWDATA[5:0];
    end
  end

  // Relay drive and edge history.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      latch_reg <= 64'h0;
      cmd_reg <= 64'h0;
      prev_r_reg <= 1'b0;
      prev_l_reg <= 1'b0;
      st_prev_reg <= 32'h0;
      lo_prev_reg <= 32'h0;
      hi_prev_reg <= 32'h0;
    end
    else
    begin
      latch_reg <= latch_next;
      cmd_reg <= cmd_next;
      prev_r_reg <= src_raise;
      prev_l_reg <= src_lower;
      st_prev_reg <= STATUS_VAL;
      lo_prev_reg <= lo_act;
      hi_prev_reg <= hi_act;
    end
  end

  // Alarm queue; flops rather than memory so the head is read in the same cycle.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      pend_reg <= '0;
      wp_reg <= 3'h0;
      rp_reg <= 3'h0;
      qcnt_reg <= 4'h0;
      ack_reg <= rca_pkg::ACK_WAIT;
      alert_reg <= 1'b0;
      for (int i = 0; i < rca_pkg::Q_DEPTH; i++)
        q_reg[i] <= '0;
    end
    else
    begin
      pend_reg <= pend_next;
      if (push)
        q_reg[wp_reg] <= new_ent;
      wp_reg <= wp_reg + {2'h0, push};
      rp_reg <= rp_reg + {2'h0, second};
      qcnt_reg <= qcnt_next;
      ack_reg <= ack_next;
      alert_reg <= alert_next;
    end
  end

  // Shared flash timebase keeps every flashing lamp in phase.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      fcnt_reg <= '0;
      flash_reg <= 1'b0;
    end
    else
    begin
      fcnt_reg <= fwrap ? '0 : fcnt_reg + 1'b1;
      flash_reg <= flash_reg ^ fwrap;
    end
  end

  // Panel indicator flops.
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      rled_reg <= 1'b0;
      lled_reg <= 1'b0;
      oled_reg <= 1'b0;
      aud_reg <= 1'b0;
      dflash_reg <= 1'b0;
      sled_reg <= 32'h0;
      lowled_reg <= 1'b0;
      hiled_reg <= 1'b0;
    end
    else
    begin
      rled_reg <= lamp_reg | (sel_latch & on_now);
      lled_reg <= lamp_reg | (sel_latch & ~on_now);
      oled_reg <= lamp_reg | ovr_reg;
      aud_reg <= alert_reg & ALARM_ENABLE;
      dflash_reg <= alert_reg & flash_reg;
      sled_reg <= sled_next;
      lowled_reg <= low_next;
      hiled_reg <= hi_next;
    end
  end

  // One mute gate per telemetry channel.
  for (genvar g = 0; g < rca_pkg::NUM_CH; g++)
  begin : g_mute
    rca_mute_gate #(.HOLD_CYC(MUTE_HOLD_CYC)) u_gate (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .mute_sel(mute_reg[g]),
      .status(STATUS_VAL),
      .limits_on(LIMITS_ON),
      .chk_en(chk_en[g])
    );
  end

  assign HRDATA = rdata_reg;
  assign HREADYOUT = rdy_reg;
  assign HRESP = resp_reg;
  assign CMD_OUT = cmd_reg;
  assign FS_TERMINATE = ovr_reg;
  assign RAISE_LED = rled_reg;
  assign LOWER_LED = lled_reg;
  assign OVERRIDE_LED = oled_reg;
  assign LAMP_TEST = lamp_reg;
  assign AUDIBLE = aud_reg;
  assign DISP_FLASH = dflash_reg;
  assign STATUS_LED = sled_reg;
  assign LOW_LED = lowled_reg;
  assign OVER_LIMIT_LED = hiled_reg;
  assign CHK_EN = chk_en;

  default clocking dcb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  a_fs_hold_off: assert property (fs_block |=> CMD_OUT == 64'h0)
    else $error("Relay active during failsafe.");
  a_first_ack_sel: assert property (first |=> shown && sel_reg == $past(head.chan))
    else $error("First acknowledge did not select the alarm.");
  a_second_ack_pop: assert property (second && !push |=>
    !shown && qcnt_reg == $past(qcnt_reg) - 4'h1)
    else $error("Second acknowledge did not retire the alarm.");
  a_alert_sounds: assert property (push ##1 ALARM_ENABLE |=> AUDIBLE)
    else $error("Audible alarm silent after a new alarm.");
  a_lamp_toggle: assert property (lamp_p |=> LAMP_TEST != $past(LAMP_TEST))
    else $error("Lamp test did not toggle.");
  a_ovr_toggle: assert property (ovr_p |=> FS_TERMINATE != $past(FS_TERMINATE))
    else $error("Override did not toggle.");
  a_ovr_led_lit: assert property (ovr_reg |=> OVERRIDE_LED)
    else $error("Override indicator dark in override.");
  a_map_clear: assert property (wm_ok && !wm_low && wm_num == 7'h00 |=> sr == 7'h00)
    else $error("Raise entry not cleared by zero.");
  a_latch_map_off: assert property (wm_ok && set_vec == 64'h0 |=>
    (latch_reg & $past(clr_map)) == 64'h0)
    else $error("Latched output not off after mapping change.");
  a_flash_phase: assert property (!fwrap |=> $stable(flash_reg))
    else $error("Flash toggled off its timebase.");
  c_first_ack: cover property (first);
  c_second_ack: cover property (second ##1 first);
  c_latch_on: cover property (set_vec != 64'h0);
  c_fs_block: cover property (fs_block && (mom != 64'h0));
endmodule // rca_top

// file: dv/rca_far_end.sv
// Distant control terminal model that drives the remote raise and lower lines.
`timescale 1ns/1ps
module rca_far_end (
  // Clock
  input wire logic clk,
  // Requested command from the bench
  input wire logic [4:0] chan_req,
  input wire logic [1:0] key_req,
  // Remote command lines
  output logic [4:0] rmt_chan,
  output logic rmt_raise,
  output logic rmt_lower
);
  // Lines move only on an edge, so a request is never seen half changed.
  always_ff @(posedge clk)
  begin
    rmt_chan <= chan_req;
    rmt_raise <= key_req[0];
    rmt_lower <= key_req[1];
  end
endmodule // rca_far_end

// file: dv/test_rca_top.sv
// Self-checking bench for the remote command and alarm logic.
`timescale 1ns/1ps
module test_rca_top;
  logic REF_CLK = 0, SYS_RST = 1, HWRITE = 0, LIMITS_ON = 1, ALARM_ENABLE = 1, FS_ACTIVE = 0;
  logic FS_START = 0, FS_EXPIRE = 0, HREADY, HREADYOUT, HRESP, FS_TERMINATE, RAISE_LED;
  logic LOWER_LED, OVERRIDE_LED, LAMP_TEST, AUDIBLE, DISP_FLASH, LOW_LED, OVER_LIMIT_LED;
  logic RMT_RAISE, RMT_LOWER;
  logic [1:0] HTRANS = 0, rkey = 0;
  logic [4:0] RMT_CHAN;
  logic [31:0] HADDR = 0, HWDATA = 0, STATUS_VAL = 0, HRDATA, STATUS_LED, CHK_EN, d;
  logic [31:0] LOW_VIOL = 0, HIGH_VIOL = 0;
  logic [63:0] CMD_OUT;
  int bad_count, total_checks, ch, n, m, l, s;
  // The single slave's ready closes the bus loop.
  assign HREADY = HREADYOUT;
  rca_top #(.MUTE_HOLD_CYC(20), .FLASH_HALF_CYC(4)) u_rca_top (.REF_CLK, .SYS_RST,
    .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY, .HRDATA,
    .HREADYOUT, .HRESP, .STATUS_VAL, .LOW_VIOL, .HIGH_VIOL, .LIMITS_ON,
    .ALARM_ENABLE, .FS_ACTIVE, .FS_START, .FS_EXPIRE, .RMT_CHAN, .RMT_RAISE,
    .RMT_LOWER, .CMD_OUT, .FS_TERMINATE, .RAISE_LED, .LOWER_LED, .OVERRIDE_LED,
    .LAMP_TEST, .AUDIBLE, .DISP_FLASH, .STATUS_LED, .LOW_LED, .OVER_LIMIT_LED, .CHK_EN);
  rca_far_end u_rca_far_end (.clk(REF_CLK), .chan_req(ch[4:0]), .key_req(rkey),
    .rmt_chan(RMT_CHAN), .rmt_raise(RMT_RAISE), .rmt_lower(RMT_LOWER));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for ready, so a stuck slave ends the run instead of hanging it.
  task automatic hrdy;
    int i;
    i = 0;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1 && ++i < 50);
    if (i >= 50) bad_count++;
    if (i >= 50) end_sim;
  endtask
  // One single word transfer; read data are taken at the data phase's closing edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge REF_CLK);
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    hrdy();
    HTRANS <= 2'h0;
    HWDATA <= wd;
    hrdy();
    d = HRDATA;
  endtask
  // Checks sit on falling edges, clear of the design's updates.
  task automatic at(input int k);
    repeat (k) @(negedge REF_CLK);
  endtask
  task automatic key(input logic [31:0] v);
    bus(1'b1, rca_pkg::OFS_KEYS, v);
    at(3);
  endtask
  task automatic map2(input int c, input int r, input int lw);
    bus(1'b1, rca_pkg::OFS_CHAN, c);
    bus(1'b1, rca_pkg::OFS_MAP, r);
    bus(1'b1, rca_pkg::OFS_MAP, 32'h100 | lw);
  endtask
  // Free-running system clock.
  initial forever #5 REF_CLK = ~REF_CLK;
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    void'($urandom(32'h559df497));
    ch = $urandom % 32;
    n = $urandom % 64 + 1;
    m = n % 64 + 1;
    l = m % 64 + 1;
    s = $urandom % 32 + 1;
    bus(1'b0, rca_pkg::OFS_MAP, 0);
    chk(d, 0);
    bus(1'b0, 8'h40, 0);
    chk(d, 0);
    // Out of override the local raise key is dead and the remote lines act.
    map2(ch, n, m);
    bus(1'b0, rca_pkg::OFS_MAP, 0);
    chk(d, (m << 8) | n);
    key(1);
    chk(CMD_OUT, 0);
    key(0);
    @(posedge REF_CLK) rkey <= 2'h1;
    at(4);
    chk(CMD_OUT, 64'h1 << (n - 1));
    @(posedge REF_CLK) FS_ACTIVE <= 1'b1;
    at(3);
    chk(CMD_OUT, 0);
    @(posedge REF_CLK) FS_ACTIVE <= 1'b0;
    rkey <= 2'h2;
    at(4);
    chk(CMD_OUT, 64'h1 << (m - 1));
    // Override: the held remote lower is ignored and the local raise acts.
    key(32'h10);
    chk({OVERRIDE_LED, FS_TERMINATE}, 2'b11);
    chk(CMD_OUT, 0);
    key(1);
    chk(CMD_OUT, 64'h1 << (n - 1));
    key(0);
    // One number on both keys of the next channel makes a latching output.
    map2((ch + 1) % 32, l, l);
    at(2);
    chk({RAISE_LED, LOWER_LED}, 2'b01);
    key(1);
    key(0);
    chk(RAISE_LED, 1);
    chk(CMD_OUT, 64'h1 << (l - 1));
    key(2);
    chk(CMD_OUT, 0);
    // Clearing both entries of a latched channel drops its output and frees the keys.
    key(1);
    chk(CMD_OUT, 64'h1 << (l - 1));
    map2((ch + 1) % 32, 0, 0);
    at(2);
    chk(CMD_OUT, 0);
    chk({RAISE_LED, LOWER_LED}, 2'b00);
    key(0);
    key(1);
    chk(CMD_OUT, 0);
    key(0);
    key(8);
    chk({LAMP_TEST, STATUS_LED}, 33'h1ffffffff);
    key(8);
    chk(LAMP_TEST, 0);
    key(32'h10);
    chk(OVERRIDE_LED, 0);
    // A failsafe start alarm sounds until the first of two acknowledges.
    @(posedge REF_CLK) FS_START <= 1'b1;
    @(posedge REF_CLK) FS_START <= 1'b0;
    at(4);
    chk(AUDIBLE, 1);
    d = DISP_FLASH;
    at(4);
    chk(DISP_FLASH ^ d[0], 1);
    key(4);
    chk(AUDIBLE, 0);
    bus(1'b0, rca_pkg::OFS_STATE, 0);
    chk(d, 32'h418);
    key(4);
    bus(1'b0, rca_pkg::OFS_STATE, 0);
    chk(d, 0);
    // A muted channel checks again only after its status has been on for the hold.
    bus(1'b1, rca_pkg::OFS_CHAN, ch);
    bus(1'b1, rca_pkg::OFS_MUTE, s);
    at(3);
    chk(CHK_EN[ch], 0);
    @(posedge REF_CLK) STATUS_VAL <= 32'h1 << (s - 1);
    at(12);
    chk(CHK_EN[ch], 0);
    at(14);
    chk(CHK_EN[ch], 1);
    bus(1'b0, rca_pkg::OFS_MUTE, 0);
    chk(d, s);
    // Low, high and expiry alarms queue in arrival order and are served oldest first.
    @(posedge REF_CLK) LOW_VIOL <= 32'h1 << ch;
    @(posedge REF_CLK) HIGH_VIOL <= 32'h1 << ch;
    FS_EXPIRE <= 1'b1;
    @(posedge REF_CLK) FS_EXPIRE <= 1'b0;
    at(4);
    bus(1'b0, rca_pkg::OFS_STATE, 0);
    chk(d, (ch << 16) | 32'h234);
    key(4);
    d = LOW_LED;
    at(4);
    chk(LOW_LED ^ d[0], 1);
    key(4);
    chk(AUDIBLE, 1);
    at(4);
    chk(LOW_LED, 1);
    key(4);
    d = OVER_LIMIT_LED;
    at(4);
    chk(OVER_LIMIT_LED ^ d[0], 1);
    key(4);
    key(4);
    bus(1'b0, rca_pkg::OFS_STATE, 0);
    chk(d, 32'h518);
    key(4);
    // A live violation stays lit until its mute status drops.
    bus(1'b1, rca_pkg::OFS_CHAN, ch);
    at(2);
    chk(LOW_LED, 1);
    @(posedge REF_CLK) STATUS_VAL <= 32'h0;
    at(4);
    chk(LOW_LED, 0);
    end_sim;
  end
endmodule // test_rca_top
